// File: core/cpu_alu_branch_exec.sv
// What this block does
// (RL1) add with carry: both registers plus carry
// (RL2) register subtract with borrow, one cycle
// (RL3) constant subtract with borrow, one cycle
// (RL4) word add/subtract: two cycles, sixteen-bit flags
// (RL5) and, or, xor: one cycle, Z N V
// (RL6) clear bits: and with ff minus constant
// (RL7) test: register and itself, Z N V
// (RL8) compare immediate: difference not stored, flags updated
// (RL9) pointer jump: pc from Z, two cycles
// (RL10) pointer call: push return, pc from Z
// (RL11) compare equal skip: 1/2/3 cycles, no flags
// (RL12) skip when register bit is zero
// (RL13) skip when I/O bit is one
// (RL14) flag branch: pc plus offset plus one
// (RL15) signed branches use N xor V
// (RL16) unsigned branches use carry
// (RL17) interrupt-enable branch uses I flag
// (RL18) half-carry branch uses H flag
// (RL19) I/O bit set/clear: two cycles, no flags
// (RL20) I/O bit access only 0x00 to 0x1f
// (RL21) I/O bit write touches only named bit
// (RL22) skip costs 2 or 3, else 1
// (RL23) relative jump 2 cycles, call 3
module cpu_alu_branch_exec (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // instruction issue
  input wire logic in_valid,
  output logic in_ready,
  input exec_pkg::instr_t in_instr,
  // results toward register file, stack and I/O space
  output exec_pkg::result_t res_out,
  output logic [7:0] flags_out,
  output logic [exec_pkg::PC_W-1:0] pc_out,
  output logic push_stb,
  output logic [exec_pkg::PC_W-1:0] push_addr,
  output exec_pkg::io_bit_t io_bit_out,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import exec_pkg::*;

  st_t st_q;
  logic run_q;
  logic [7:0] flags_q;
  logic [PC_W-1:0] pc_q;
  result_t res_q;
  logic push_q;
  logic [PC_W-1:0] push_addr_q;
  io_bit_t io_q;
  io_bit_t io_pend_q;
  logic ack_q;
  logic [31:0] rdata_q;

  logic issue;
  logic [7:0] a8;
  logic [7:0] opb;
  logic cin;
  logic [8:0] sum9;
  logic [8:0] dif9;
  logic [4:0] hsum;
  logic [4:0] hdif;
  logic [16:0] w17;
  logic [7:0] r8;
  logic [7:0] flags_d;
  logic [PC_W-1:0] pc_d;
  logic [1:0] cyc;
  result_t res_d;
  logic push_d;
  io_bit_t io_d;
  logic cond;
  logic skip_hit;
  logic [PC_W-1:0] rel_tgt;
  logic [PC_W-1:0] skip_tgt;
  logic bus_req;
  logic bus_wr;

  // a new instruction is only taken when running and not mid-sequence
  assign in_ready = ce & run_q & (st_q == ST_RUN);
  assign issue = in_valid & in_ready;

  // operand selection and the shared adders
  always_comb
  begin
    a8 = in_instr.dst[7:0];
    opb = in_instr.use_imm ? in_instr.imm : in_instr.src;
    cin = 1'b0;
    if (in_instr.op == OP_ADC || in_instr.op == OP_SBC ||
        in_instr.op == OP_CMPC)
    begin
      cin = flags_q[FLAG_C]; // [RL1] [RL2] [RL3]
    end
    sum9 = {1'b0, a8} + {1'b0, opb} + {8'h00, cin};
    dif9 = {1'b0, a8} - {1'b0, opb} - {8'h00, cin};
    hsum = {1'b0, a8[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    hdif = {1'b0, a8[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
    if (in_instr.op == OP_WSUB)
    begin
      w17 = {1'b0, in_instr.dst} - {9'h000, in_instr.imm};
    end
    else
    begin
      w17 = {1'b0, in_instr.dst} + {9'h000, in_instr.imm};
    end
  end

  // branch and skip targets, condition from the selected flag
  always_comb
  begin
    rel_tgt = pc_q + in_instr.offset + PC_W'(1); // [RL14] [RL23]
    skip_tgt = pc_q + (in_instr.next_two_word ? PC_W'(3) : PC_W'(2));
    // S holds N xor V, so signed tests select it directly
    cond = (flags_q[in_instr.sel] == in_instr.pol); // [RL15] [RL16]
    skip_hit = 1'b0;
    case (in_instr.op)
      OP_COMPARE_EQUAL_SKIP: skip_hit = (a8 == in_instr.src); // [RL11]
      OP_RBIT_SKIP: skip_hit = (in_instr.src[in_instr.sel] == in_instr.pol);
      OP_IOBIT_SKIP:
        skip_hit = (in_instr.io_addr <= IO_BIT_LAST) &&
                   (in_instr.io_val[in_instr.sel] == in_instr.pol);
      default: skip_hit = 1'b0;
    endcase
  end

  // execution: result, flags, next pc and cycle count
  always_comb
  begin
    flags_d = flags_q;
    pc_d = pc_q + PC_W'(1);
    cyc = CYC_ONE;
    res_d = '0;
    push_d = 1'b0;
    io_d = '0;
    r8 = 8'h00;
    case (in_instr.op)
      OP_ADD, OP_ADC:
      begin
        r8 = sum9[7:0]; // [RL1]
        res_d = '{we: 1'b1, wide: 1'b0, data: {8'h00, r8}};
        flags_d[FLAG_C] = sum9[8];
        flags_d[FLAG_H] = hsum[4];
        flags_d[FLAG_V] = (a8[7] & opb[7] & ~r8[7]) |
                          (~a8[7] & ~opb[7] & r8[7]);
      end
      OP_SUB, OP_SBC, OP_CMP, OP_CMPC:
      begin
        r8 = dif9[7:0]; // [RL2] [RL3]
        // compares keep the register untouched
        res_d = '{we: (in_instr.op == OP_SUB || in_instr.op == OP_SBC),
                  wide: 1'b0, data: {8'h00, r8}}; // [RL8]
        flags_d[FLAG_C] = dif9[8];
        flags_d[FLAG_H] = hdif[4];
        flags_d[FLAG_V] = (a8[7] & ~opb[7] & ~r8[7]) |
                          (~a8[7] & opb[7] & r8[7]);
      end
      OP_AND, OP_OR, OP_XOR, OP_CLRBITS, OP_TEST:
      begin
        case (in_instr.op)
          OP_AND: r8 = a8 & opb; // [RL5]
          OP_OR: r8 = a8 | opb;
          OP_XOR: r8 = a8 ^ opb;
          OP_CLRBITS: r8 = a8 & (ALL_ONES - opb); // [RL6]
          default: r8 = a8 & a8; // [RL7]
        endcase
        res_d = '{we: (in_instr.op != OP_TEST), wide: 1'b0,
                  data: {8'h00, r8}};
        flags_d[FLAG_V] = 1'b0;
      end
      OP_WADD, OP_WSUB:
      begin
        cyc = CYC_TWO; // [RL4]
        res_d = '{we: 1'b1, wide: 1'b1, data: w17[15:0]};
        flags_d[FLAG_N] = w17[15];
        flags_d[FLAG_Z] = (w17[15:0] == 16'h0000);
        if (in_instr.op == OP_WADD)
        begin
          flags_d[FLAG_V] = ~in_instr.dst[15] & w17[15];
          flags_d[FLAG_C] = ~w17[15] & in_instr.dst[15];
        end
        else
        begin
          flags_d[FLAG_V] = in_instr.dst[15] & ~w17[15];
          flags_d[FLAG_C] = w17[15] & ~in_instr.dst[15];
        end
        flags_d[FLAG_S] = flags_d[FLAG_N] ^ flags_d[FLAG_V];
      end
      OP_PJMP:
      begin
        pc_d = in_instr.z_ptr[PC_W-1:0]; // [RL9]
        cyc = CYC_TWO;
      end
      OP_PCALL:
      begin
        pc_d = in_instr.z_ptr[PC_W-1:0]; // [RL10]
        push_d = 1'b1;
        cyc = CYC_THREE;
      end
      OP_RJMP:
      begin
        pc_d = rel_tgt; // [RL23]
        cyc = CYC_TWO;
      end
      OP_RCALL:
      begin
        pc_d = rel_tgt; // [RL23]
        push_d = 1'b1;
        cyc = CYC_THREE;
      end
      OP_COMPARE_EQUAL_SKIP, OP_RBIT_SKIP, OP_IOBIT_SKIP:
      begin
        if (skip_hit) // [RL12] [RL13]
        begin
          pc_d = skip_tgt;
          cyc = in_instr.next_two_word ? CYC_THREE : CYC_TWO; // [RL22]
        end
      end
      OP_BRANCH:
      begin
        // sel picks I for interrupt-enable, H for half-carry tests
        if (cond) // [RL17] [RL18]
        begin
          pc_d = rel_tgt; // [RL14]
          cyc = CYC_TWO;
        end
      end
      OP_IO_HIGH, OP_IO_LOW:
      begin
        cyc = CYC_TWO; // [RL19]
        // outside the bit-addressable window nothing is written
        io_d.stb = (in_instr.io_addr <= IO_BIT_LAST); // [RL20]
        io_d.addr = in_instr.io_addr[4:0];
        io_d.bit_idx = in_instr.sel; // [RL21]
        io_d.level = (in_instr.op == OP_IO_HIGH);
      end
      default: pc_d = pc_q + PC_W'(1);
    endcase
    // N, Z and S follow every byte-wide flag-setting op
    if (in_instr.op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP,
                            OP_CMPC, OP_AND, OP_OR, OP_XOR, OP_CLRBITS,
                            OP_TEST})
    begin
      flags_d[FLAG_N] = r8[7];
      flags_d[FLAG_Z] = (r8 == 8'h00);
      flags_d[FLAG_S] = flags_d[FLAG_N] ^ flags_d[FLAG_V];
    end
  end

  // wait states for multi-cycle instructions
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_RUN;
    end
    else if (ce)
    begin
      case (st_q)
        ST_RUN:
        begin
          if (issue && cyc == CYC_THREE)
          begin
            st_q <= ST_HOLD2;
          end
          else if (issue && cyc == CYC_TWO)
          begin
            st_q <= ST_HOLD1;
          end
        end
        ST_HOLD2: st_q <= ST_HOLD1;
        ST_HOLD1: st_q <= ST_RUN;
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // program counter; a bus load wins over execution
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q <= PC_RST;
    end
    else if (ce)
    begin
      if (bus_wr && address == OFS_PC && byteenable[0])
      begin
        pc_q <= writedata[PC_W-1:0];
      end
      else if (issue)
      begin
        pc_q <= pc_d;
      end
    end
  end

  // flag word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_q <= FLAGS_RST;
    end
    else if (ce)
    begin
      if (bus_wr && address == OFS_FLAGS && byteenable[0])
      begin
        flags_q <= writedata[7:0];
      end
      else if (issue)
      begin
        flags_q <= flags_d;
      end
    end
  end

  // result and return-address strobes, one cycle each
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_q <= '0;
      push_q <= 1'b0;
      push_addr_q <= PC_RST;
    end
    else if (ce)
    begin
      res_q <= issue ? res_d : '0;
      push_q <= issue & push_d; // [RL10]
      if (issue && push_d)
      begin
        push_addr_q <= pc_q + PC_W'(1);
      end
    end
  end

  // I/O bit write lands in the cycle after the instruction's second cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_pend_q <= '0;
      io_q <= '0;
    end
    else if (ce)
    begin
      io_pend_q <= issue ? io_d : '0;
      io_q <= io_pend_q; // [RL19]
    end
  end

  // bus slave: one wait state, registered read data
  assign bus_req = (read | write) & ce;
  assign bus_wr = write & ack_q;
  assign waitrequest = (read | write) & ~ack_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_q <= bus_req & ~ack_q;
      if (read && !ack_q)
      begin
        case (address)
          OFS_CTRL: rdata_q <= {31'h0000_0000, run_q};
          OFS_PC: rdata_q <= {20'h0_0000, pc_q};
          OFS_FLAGS: rdata_q <= {24'h00_0000, flags_q};
          OFS_STATUS: rdata_q <= {29'h0000_0000, st_q, ~in_ready};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; run gates instruction issue
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= CTRL_RUN_RST;
    end
    else if (ce && bus_wr && address == OFS_CTRL && byteenable[0])
    begin
      run_q <= writedata[CTRL_RUN_BIT];
    end
  end

  assign res_out = res_q;
  assign flags_out = flags_q;
  assign pc_out = pc_q;
  assign push_stb = push_q;
  assign push_addr = push_addr_q;
  assign io_bit_out = io_q;
  assign readdata = rdata_q;

endmodule // cpu_alu_branch_exec

// File: core/exec_pkg.sv
package exec_pkg;

  // program counter width in instruction words
  localparam int PC_W = 12;

  // flag word bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  localparam logic CTRL_RUN_RST = 1'b0;

  // operand constants
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [5:0] IO_BIT_LAST = 6'h1f;

  // register byte offsets on the bus
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PC = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int CTRL_RUN_BIT = 0;

  // cycle counts per instruction class
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_TWO = 2'd2;
  localparam logic [1:0] CYC_THREE = 2'd3;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_ADD = 5'h01,
    OP_ADC = 5'h02,
    OP_SUB = 5'h03,
    OP_SBC = 5'h04,
    OP_CMP = 5'h05,
    OP_CMPC = 5'h06,
    OP_AND = 5'h07,
    OP_OR = 5'h08,
    OP_XOR = 5'h09,
    OP_CLRBITS = 5'h0a,
    OP_TEST = 5'h0b,
    OP_WADD = 5'h0c,
    OP_WSUB = 5'h0d,
    OP_PJMP = 5'h0e,
    OP_PCALL = 5'h0f,
    OP_RJMP = 5'h10,
    OP_RCALL = 5'h11,
    OP_COMPARE_EQUAL_SKIP = 5'h12,
    OP_RBIT_SKIP = 5'h13,
    OP_IOBIT_SKIP = 5'h14,
    OP_BRANCH = 5'h15,
    OP_IO_HIGH = 5'h16,
    OP_IO_LOW = 5'h17
  } op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD2 = 2'b11,
    ST_HOLD1 = 2'b01
  } st_t;

  typedef struct packed {
    op_t op;
    logic use_imm;
    logic [15:0] dst;
    logic [7:0] src;
    logic [7:0] imm;
    logic [2:0] sel;
    logic pol;
    logic [PC_W-1:0] offset;
    logic [5:0] io_addr;
    logic [7:0] io_val;
    logic next_two_word;
    logic [15:0] z_ptr;
  } instr_t;

  typedef struct packed {
    logic we;
    logic wide;
    logic [15:0] data;
  } result_t;

  typedef struct packed {
    logic stb;
    logic [4:0] addr;
    logic [2:0] bit_idx;
    logic level;
  } io_bit_t;

endpackage

// File: test/exec_chk_assertions.sv
module exec_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire logic in_valid,
  input wire logic in_ready,
  input exec_pkg::instr_t in_instr,
  // results
  input exec_pkg::result_t res_out,
  input wire logic [7:0] flags_out,
  input wire logic [exec_pkg::PC_W-1:0] pc_out,
  input wire logic push_stb,
  input wire logic [exec_pkg::PC_W-1:0] push_addr,
  input exec_pkg::io_bit_t io_bit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  instr_t ins_q;
  instr_t in2_q;
  logic [7:0] fl_q;
  logic [PC_W-1:0] pc_q;
  logic take;
  op_t op;
  assign take = in_valid && in_ready;
  assign op = in_instr.op;
  // one- and two-cycle history so results can be tied to what was issued
  always_ff @(posedge clk)
  begin
    ins_q <= in_instr;
    in2_q <= ins_q;
    fl_q <= flags_out;
    pc_q <= pc_out;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_ADD_CARRY: assert property (take && op == OP_ADC |=> res_out.we &&
    res_out.data[7:0] == 8'(ins_q.dst[7:0] + ins_q.src + fl_q[FLAG_C]))
    else $error("add with carry result wrong");
  AST_WORD_TWO: assert property (take && op inside {OP_WADD, OP_WSUB}
    |=> res_out.wide && !in_ready ##1 in_ready)
    else $error("word op timing wrong");
  AST_LOGIC_KEEP: assert property (take &&
    op inside {OP_AND, OP_OR, OP_XOR, OP_CLRBITS, OP_TEST} |=>
    flags_out[FLAG_C] == fl_q[FLAG_C] && flags_out[FLAG_H] == fl_q[FLAG_H])
    else $error("logic op touched carry or half carry");
  AST_CMP_NOSTORE: assert property (take && op == OP_CMP &&
    in_instr.use_imm |=> !res_out.we &&
    flags_out[FLAG_Z] == (ins_q.dst[7:0] == ins_q.imm))
    else $error("compare stored or zero flag wrong");
  AST_FLAGS_KEEP: assert property (take && op inside {OP_PJMP,
    OP_PCALL, OP_COMPARE_EQUAL_SKIP, OP_RBIT_SKIP, OP_IOBIT_SKIP, OP_BRANCH,
    OP_IO_HIGH, OP_IO_LOW} |=> flags_out == fl_q)
    else $error("control op changed flags");
  AST_PCALL: assert property (take && op == OP_PCALL |=> push_stb &&
    push_addr == 12'(pc_q + 1) && pc_out == ins_q.z_ptr[PC_W-1:0] &&
    !in_ready ##1 !in_ready ##1 in_ready)
    else $error("pointer call wrong");
  AST_BRANCH: assert property (take && op == OP_BRANCH |=>
    pc_out == ((fl_q[ins_q.sel] == ins_q.pol) ?
    12'(pc_q + ins_q.offset + 1) : 12'(pc_q + 1)))
    else $error("branch target wrong");
  AST_SKIP3: assert property (take && op inside {OP_COMPARE_EQUAL_SKIP,
    OP_RBIT_SKIP, OP_IOBIT_SKIP} ##1 pc_out == 12'(pc_q + 3) |->
    !in_ready ##1 !in_ready ##1 in_ready)
    else $error("long skip timing wrong");
  AST_IO_BIT: assert property (take && op == OP_IO_HIGH &&
    in_instr.io_addr <= IO_BIT_LAST |=> !io_bit_out.stb ##1
    io_bit_out.stb && io_bit_out.level &&
    io_bit_out.addr == in2_q.io_addr[4:0] && io_bit_out.bit_idx == in2_q.sel)
    else $error("io bit set wrong");
  AST_IO_RANGE: assert property (take && op inside {OP_IO_HIGH,
    OP_IO_LOW} && in_instr.io_addr > IO_BIT_LAST |-> ##2 !io_bit_out.stb)
    else $error("io bit out of range written");
  // main scenarios
  cover property (take && op == OP_PCALL);
  cover property (take && op == OP_BRANCH ##1 pc_out != 12'(pc_q + 1));
  cover property (io_bit_out.stb);
endmodule // exec_chk

bind cpu_alu_branch_exec exec_chk i_exec_chk (.*);

// File: test/io_space.sv
module io_space (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bit writes and skip lookups
  input exec_pkg::io_bit_t io_bit_out,
  input wire logic [5:0] io_addr,
  output logic [7:0] io_val
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic [7:0] regs_q [32];
  // bits 0 and 7 start set so a wide write that clears them shows
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int k = 0; k < 32; k++)
        regs_q[k] <= 8'h81;
    else if (io_bit_out.stb)
      regs_q[io_bit_out.addr][io_bit_out.bit_idx] <= io_bit_out.level;
  end
  // out of range reads all ones, so a wrongful skip is seen
  assign io_val = (io_addr > IO_BIT_LAST) ? 8'hff : regs_q[io_addr[4:0]];
endmodule // io_space

// File: test/test_cpu_alu_branch_exec.sv
module test_cpu_alu_branch_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  instr_t drv = '0;
  instr_t ins = '0;
  instr_t in_instr;
  logic in_ready, push_stb, waitrequest;
  logic [7:0] flags_out, io_val;
  logic [PC_W-1:0] pc_out, push_addr, p;
  logic [31:0] readdata, rd;
  result_t res_out;
  io_bit_t io_bit_out;
  int err_count = 0;
  int checks = 0;
  // sel, pol, flag word
  logic [11:0] bt [7] = '{12'h800, 12'h900, 12'h914, 12'h001, 12'hf80,
    12'hb20, 12'ha20};
  always #2 clk = ~clk;
  // the skip operand comes live from the io space
  always_comb
  begin
    in_instr = drv;
    in_instr.io_val = io_val;
  end
  cpu_alu_branch_exec i_cpu_alu_branch_exec (.clk(clk), .rst_n(rst_n),
    .ce(1'b1), .in_valid(in_valid), .in_ready(in_ready),
    .in_instr(in_instr), .res_out(res_out), .flags_out(flags_out),
    .pc_out(pc_out), .push_stb(push_stb), .push_addr(push_addr),
    .io_bit_out(io_bit_out), .address(address), .read(read),
    .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  io_space i_io_space (.clk(clk), .rst_n(rst_n), .io_bit_out(io_bit_out),
    .io_addr(drv.io_addr), .io_val(io_val));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // held until the edge that sees waitrequest low; data taken there
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // returns in the cycle after the take edge, pc at issue kept in p
  task go(input op_t op);
    ins.op = op;
    @(posedge clk);
    drv <= ins;
    in_valid <= 1'b1;
    do @(negedge clk); while (in_ready !== 1'b1);
    p = pc_out;
    @(posedge clk);
    in_valid <= 1'b0;
    @(negedge clk);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_count++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(pc_out, 0);
    chk(in_ready, 0);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 0);
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_FLAGS, 32'h1);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk(rd, 32'h1);
    ins.dst = 16'h003f;
    ins.src = 8'h01;
    go(OP_ADC);
    chk(res_out.data[7:0], 8'h41);
    chk(flags_out, 8'h20);
    ins.dst = 16'h0010;
    ins.imm = 8'h20;
    ins.use_imm = 1'b1;
    go(OP_SBC);
    chk(res_out.data[7:0], 8'hf0);
    chk(flags_out, 8'h15);
    ins.dst = 16'h0005;
    ins.src = 8'h02;
    ins.use_imm = 1'b0;
    go(OP_SBC);
    chk(res_out.data[7:0], 8'h02);
    chk(flags_out, 8'h00);
    ins.dst = 16'hffff;
    ins.imm = 8'h01;
    ins.use_imm = 1'b1;
    go(OP_WADD);
    chk({res_out.wide, res_out.data}, 17'h10000);
    chk(flags_out, 8'h03);
    ins.dst = 16'h00ff;
    ins.imm = 8'h0f;
    go(OP_CLRBITS);
    chk(res_out.data[7:0], 8'hf0);
    chk(flags_out, 8'h15);
    ins.dst = 16'h0080;
    ins.use_imm = 1'b0;
    go(OP_TEST);
    chk({res_out.we, flags_out}, 9'h015);
    ins.src = 8'hff;
    go(OP_XOR);
    chk(res_out.data[7:0], 8'h7f);
    chk(flags_out, 8'h01);
    go(OP_OR);
    chk({res_out.we, flags_out}, 9'h115);
    ins.dst = 16'h0005;
    ins.imm = 8'h05;
    ins.use_imm = 1'b1;
    go(OP_CMP);
    chk({res_out.we, flags_out}, 9'h002);
    $display("test arithmetic done");
    ins.z_ptr = 16'h0123;
    go(OP_PJMP);
    chk(pc_out, 12'h123);
    bus(1'b0, OFS_PC, 32'h0);
    chk(rd, 32'h123);
    ins.z_ptr = 16'h0200;
    go(OP_PCALL);
    chk({push_stb, push_addr, pc_out}, 25'h1124200);
    ins.dst = 16'h0007;
    ins.src = 8'h07;
    ins.next_two_word = 1'b1;
    go(OP_COMPARE_EQUAL_SKIP);
    chk(pc_out, p + 3);
    ins.dst = 16'h00fe;
    ins.src = 8'hfe;
    ins.sel = 3'd0;
    ins.pol = 1'b0;
    ins.next_two_word = 1'b0;
    go(OP_RBIT_SKIP);
    chk(pc_out, p + 2);
    $display("test flow done");
    ins.io_addr = 6'h03;
    ins.sel = 3'd2;
    go(OP_IO_HIGH);
    ins.sel = 3'd7;
    go(OP_IO_LOW);
    repeat (2) @(negedge clk);
    chk(i_io_space.regs_q[3], 8'h05);
    ins.io_addr = 6'h23;
    go(OP_IO_HIGH);
    ins.io_addr = 6'h03;
    ins.sel = 3'd2;
    ins.pol = 1'b1;
    go(OP_IOBIT_SKIP);
    chk(pc_out, p + 2);
    ins.io_addr = 6'h23;
    go(OP_IOBIT_SKIP);
    chk(pc_out, p + 1);
    $display("test io done");
    ins.offset = 12'hffe;
    foreach (bt[k])
    begin
      bus(1'b1, OFS_FLAGS, {24'h0, bt[k][7:0]});
      ins.sel = bt[k][11:9];
      ins.pol = bt[k][8];
      go(OP_BRANCH);
      chk(pc_out, (bt[k][bt[k][11:9]] == bt[k][8]) ? 12'(p + 12'hfff) :
        12'(p + 1));
    end
    go(OP_RJMP);
    chk(pc_out, 12'(p + 12'hfff));
    go(OP_RCALL);
    chk({push_stb, push_addr, pc_out},
      {1'b1, 12'(p + 12'h001), 12'(p + 12'hfff)});
    $display("test branch done");
    final_report;
  end
endmodule // test_cpu_alu_branch_exec
